// ==== core/srpm_consts.vh ====
// constants of the sensor register pointer map
`ifndef SRPM_CONSTS_VH
`define SRPM_CONSTS_VH

`define SRPM_PTR_W        8
`define SRPM_SEL_W        2
`define SRPM_PTR_RST      8'h00
`define SRPM_SEL_RESULT   2'h0
`define SRPM_SEL_CONFIG   2'h1
`define SRPM_SEL_LOW      2'h2
`define SRPM_SEL_HIGH     2'h3
`define SRPM_REG_W        16
`define SRPM_BYTE_W       8
`define SRPM_RESULT_RST   16'h0000
`define SRPM_CONFIG_RST   16'h40A0
`define SRPM_CONFIG_WMASK 16'h9FC0
`define SRPM_THR_RST      16'h0000
`define SRPM_THR_WMASK    16'hFFFF
`define SRPM_ALERT_BIT    5
`define SRPM_RATE_LSB     6
`define SRPM_RATE_MSB     7
`define SRPM_SEQ_IDLE     2'h0
`define SRPM_SEQ_PTR      2'h1
`define SRPM_SEQ_MSB      2'h2
`define SRPM_SEQ_LSB      2'h3

`endif

// ==== core/srpm_reg16.v ====
// one 16-bit register with a per-bit write mask
`timescale 1ns/1ps
`default_nettype none

module srpm_reg16 #(
  parameter [15:0] RESET_VAL  = 16'h0000,
  parameter [15:0] WRITE_MASK = 16'hFFFF
) (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        wr_en,
  input  wire [15:0] wr_data,
  output reg  [15:0] q_ff
);

  wire [15:0] nxt_q;

  // read-only bits keep their reset value whatever is written
  assign nxt_q = (q_ff & ~WRITE_MASK) | (wr_data & WRITE_MASK);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q_ff <= RESET_VAL;
    end else if (wr_en) begin
      q_ff <= nxt_q;
    end
  end

endmodule // srpm_reg16

`default_nettype wire

// ==== core/srpm_top.v ====
// register pointer and register bank behind the two-wire byte interface
//
// Summary of operation
// (R1) 8-bit pointer, only two low bits writable
// (R2) pointer bits 7..2 read zero; reset zero
// (R3) pointer 0..3 picks result, config, low, high
// (R4) controller sets pointer before data access
// (R5) result read-only; other three read-write
// (R6) result changes only on new processor result
// (R7) 16-bit transfers go MSB byte first
// (R8) conversion rate resets to four per second
// (R9) first write byte loads pointer, read keeps it
`timescale 1ns/1ps
`default_nettype none
`include "srpm_consts.vh"

module srpm_top (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        xfer_start,
  input  wire        xfer_is_write,
  input  wire        wr_byte_vld,
  input  wire [7:0]  wr_byte,
  input  wire        rd_byte_req,
  input  wire        result_vld,
  input  wire [15:0] result_data,
  input  wire        alert_level,
  output reg  [7:0]  rd_byte_ff,
  output reg         rd_byte_vld_ff,
  output reg  [7:0]  pointer_ff,
  output reg  [15:0] temperature_result_ff,
  output reg  [15:0] sensor_configuration_ff,
  output reg  [15:0] low_temperature_threshold_ff,
  output reg  [15:0] high_temperature_threshold_ff,
  output reg  [1:0]  conversion_rate_field_ff
);

  localparam SEQ_IDLE = `SRPM_SEQ_IDLE;
  localparam SEQ_PTR  = `SRPM_SEQ_PTR;
  localparam SEQ_MSB  = `SRPM_SEQ_MSB;
  localparam SEQ_LSB  = `SRPM_SEQ_LSB;

  // bank layout: entry 0 is the result, so the writable slice starts at entry 1
  localparam [15:0] CONFIG_RST = `SRPM_CONFIG_RST;
  localparam integer REG_W     = `SRPM_REG_W;
  localparam integer FIRST_RW  = `SRPM_SEL_CONFIG;
  localparam integer CFG_LSB   = (`SRPM_SEL_CONFIG - FIRST_RW) * REG_W;
  localparam integer LOW_LSB   = (`SRPM_SEL_LOW - FIRST_RW) * REG_W;
  localparam integer HIGH_LSB  = (`SRPM_SEL_HIGH - FIRST_RW) * REG_W;

  reg  [1:0]  seq_ff;
  reg  [1:0]  nxt_seq;
  reg  [7:0]  msb_hold_ff;
  reg         rd_lsb_ff;
  reg  [7:0]  rd_lsb_hold_ff;
  reg  [7:0]  nxt_pointer;
  reg  [15:0] sel_value;
  wire [1:0]  sel;
  wire        commit;
  wire [15:0] commit_data;
  wire [47:0] rw_regs;
  wire [15:0] config_q;
  wire [15:0] low_q;
  wire [15:0] high_q;

  assign sel         = pointer_ff[`SRPM_SEL_W-1:0];
  // whole word lands at once, so the block never sees a half-written threshold
  assign commit      = wr_byte_vld && (seq_ff == SEQ_LSB); // (R7)
  assign commit_data = {msb_hold_ff, wr_byte}; // (R7)
  assign config_q    = rw_regs[CFG_LSB +: REG_W];
  assign low_q       = rw_regs[LOW_LSB +: REG_W];
  assign high_q      = rw_regs[HIGH_LSB +: REG_W];

  // write byte sequencer
  always @* begin
    nxt_seq = seq_ff;
    case (seq_ff)
      // read transfers park here, so stray bytes cannot reach a register
      SEQ_IDLE: nxt_seq = seq_ff;
      SEQ_PTR: begin
        if (wr_byte_vld) begin
          nxt_seq = SEQ_MSB; // (R9)
        end
      end
      SEQ_MSB: begin
        if (wr_byte_vld) begin
          nxt_seq = SEQ_LSB;
        end
      end
      SEQ_LSB: begin
        // extra bytes start a new word on the same register
        if (wr_byte_vld) begin
          nxt_seq = SEQ_MSB;
        end
      end
      // all four codes are used; kept as a safe landing only
      default: nxt_seq = SEQ_IDLE;
    endcase
    if (xfer_start) begin
      nxt_seq = xfer_is_write ? SEQ_PTR : SEQ_IDLE; // (R9)
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seq_ff      <= SEQ_IDLE;
      msb_hold_ff <= 8'h00;
    end else begin
      seq_ff <= nxt_seq;
      // a lone high byte stays here and is never committed
      if (wr_byte_vld && (seq_ff == SEQ_MSB)) begin
        msb_hold_ff <= wr_byte;
      end
    end
  end

  // pointer: upper six bits are never stored, so they read as zero
  always @* begin
    nxt_pointer = pointer_ff;
    // only the first byte of a write transfer is a pointer byte
    if (wr_byte_vld && (seq_ff == SEQ_PTR) && !xfer_start) begin
      nxt_pointer = {{(`SRPM_PTR_W-`SRPM_SEL_W){1'b0}}, wr_byte[`SRPM_SEL_W-1:0]}; // (R1) (R2)
    end
  end

  // reads leave the pointer alone, so repeated reads need no new pointer byte
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pointer_ff <= `SRPM_PTR_RST; // (R2)
    end else begin
      pointer_ff <= nxt_pointer; // (R9)
    end
  end

  // result is loaded by the signal processor only; bus writes never reach it
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      temperature_result_ff <= `SRPM_RESULT_RST;
    end else if (result_vld) begin
      temperature_result_ff <= result_data; // (R6) (R5)
    end
  end

  // writable registers, entry i sits at pointer value i
  // there is no entry 0: bus writes aimed at the result simply vanish
  genvar gi;
  generate
    for (gi = FIRST_RW; gi <= `SRPM_SEL_HIGH; gi = gi + 1) begin : g_rw
      localparam integer IDX = gi;
      localparam [15:0]  RV  = (gi == FIRST_RW) ? CONFIG_RST : `SRPM_THR_RST;
      localparam [15:0]  WM  = (gi == FIRST_RW) ? `SRPM_CONFIG_WMASK : `SRPM_THR_WMASK;
      wire [15:0] q;
      srpm_reg16 #(
        .RESET_VAL  (RV),
        .WRITE_MASK (WM)
      ) u_reg (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    (commit && (sel == IDX[`SRPM_SEL_W-1:0]) && !xfer_start), // (R3) (R5) (R4)
        .wr_data  (commit_data),
        .q_ff     (q)
      );
      assign rw_regs[(gi-FIRST_RW)*REG_W +: REG_W] = q;
    end
  endgenerate

  // mirrors are flops so every output leaves straight from a register
  // cost: the mirrors trail the bank by one cycle
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sensor_configuration_ff       <= CONFIG_RST;
      low_temperature_threshold_ff  <= `SRPM_THR_RST;
      high_temperature_threshold_ff <= `SRPM_THR_RST;
      conversion_rate_field_ff      <= CONFIG_RST[`SRPM_RATE_MSB:`SRPM_RATE_LSB]; // (R8)
    end else begin
      sensor_configuration_ff       <= config_q;
      low_temperature_threshold_ff  <= low_q;
      high_temperature_threshold_ff <= high_q;
      conversion_rate_field_ff      <= config_q[`SRPM_RATE_MSB:`SRPM_RATE_LSB];
    end
  end

  // read selection; the alert bit of the configuration is live
  always @* begin
    case (sel)
      `SRPM_SEL_RESULT: sel_value = temperature_result_ff; // (R3)
      `SRPM_SEL_CONFIG: begin
        sel_value = config_q;
        sel_value[`SRPM_ALERT_BIT] = alert_level;
      end
      `SRPM_SEL_LOW:    sel_value = low_q;
      `SRPM_SEL_HIGH:   sel_value = high_q;
      // two select bits cover every code; never taken
      default:          sel_value = `SRPM_RESULT_RST;
    endcase
  end

  // low byte is captured with the high byte so a new result cannot split a word
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_lsb_ff      <= 1'b0;
      rd_lsb_hold_ff <= 8'h00;
      rd_byte_ff     <= 8'h00;
      rd_byte_vld_ff <= 1'b0;
    end else begin
      // a request in the start cycle is dropped, as the phase restarts there
      rd_byte_vld_ff <= rd_byte_req && !xfer_start;
      if (xfer_start) begin
        rd_lsb_ff <= 1'b0; // (R9)
      end else if (rd_byte_req) begin
        rd_lsb_ff <= ~rd_lsb_ff;
        if (!rd_lsb_ff) begin
          rd_byte_ff     <= sel_value[15:8]; // (R7)
          rd_lsb_hold_ff <= sel_value[7:0];
        end else begin
          rd_byte_ff <= rd_lsb_hold_ff; // (R7)
        end
      end
    end
  end

endmodule // srpm_top

`default_nettype wire

// ==== sim/srpm_props_properties.sv ====
// assertions on the pointer map ports
`timescale 1ns/1ps
`default_nettype none
module srpm_props (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        xfer_start,
  input wire logic        xfer_is_write,
  input wire logic        wr_byte_vld,
  input wire logic        rd_byte_req,
  input wire logic        result_vld,
  input wire logic [15:0] result_data,
  input wire logic [7:0]  rd_byte_ff,
  input wire logic        rd_byte_vld_ff,
  input wire logic [7:0]  pointer_ff,
  input wire logic [15:0] temperature_result_ff,
  input wire logic [1:0]  conversion_rate_field_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_ptr_upper_zero: assert property (pointer_ff[7:2] == 6'h00)
    else $error("pointer upper bits set");
  a_ptr_only_write: assert property (!wr_byte_vld |=> $stable(pointer_ff))
    else $error("pointer moved without byte");
  a_rd_answer: assert property (rd_byte_req && !xfer_start |=> rd_byte_vld_ff)
    else $error("read byte not answered");
  a_rd_cause: assert property (rd_byte_vld_ff |-> $past(rd_byte_req))
    else $error("read byte without request");
  a_result_load: assert property (result_vld |=> temperature_result_ff == $past(result_data))
    else $error("result not loaded");
  a_result_hold: assert property (!result_vld |=> $stable(temperature_result_ff))
    else $error("result changed without load");
  a_rate_reset: assert property ($fell(rst) |-> conversion_rate_field_ff == 2'h2)
    else $error("rate not four per second");
  a_msb_first: assert property (xfer_start && !xfer_is_write && pointer_ff == 8'h00 ##1
    rd_byte_req && !result_vld |=> rd_byte_ff == $past(temperature_result_ff[15:8]))
    else $error("first byte not result msb");
endmodule // srpm_props
bind srpm_top srpm_props u_props (
  .core_clk                 (core_clk),
  .rst                      (rst),
  .xfer_start               (xfer_start),
  .xfer_is_write            (xfer_is_write),
  .wr_byte_vld              (wr_byte_vld),
  .rd_byte_req              (rd_byte_req),
  .result_vld               (result_vld),
  .result_data              (result_data),
  .rd_byte_ff               (rd_byte_ff),
  .rd_byte_vld_ff           (rd_byte_vld_ff),
  .pointer_ff               (pointer_ff),
  .temperature_result_ff    (temperature_result_ff),
  .conversion_rate_field_ff (conversion_rate_field_ff)
);
`default_nettype wire

// ==== sim/srpm_ctl_model.sv ====
// bus controller model driving the byte interface
`timescale 1ns/1ps
`default_nettype none
module srpm_ctl (
  input wire logic       core_clk,
  input wire logic [7:0] rd_byte_ff,
  output var logic       xfer_start,
  output var logic       xfer_is_write,
  output var logic       wr_byte_vld,
  output var logic [7:0] wr_byte,
  output var logic       rd_byte_req
);
  initial begin
    {xfer_start, xfer_is_write, wr_byte_vld, rd_byte_req} = 4'h0;
    wr_byte = 8'h00;
  end
  task automatic go(input logic w);
    @(posedge core_clk) #1 xfer_start = 1'b1;
    xfer_is_write = w;
    @(posedge core_clk) #1 xfer_start = 1'b0;
  endtask
  // strobe stays high between bytes; caller drops it
  task automatic put(input logic [7:0] b);
    wr_byte_vld = 1'b1;
    wr_byte = b;
    @(posedge core_clk) #1;
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] v, input logic ponly);
    go(1'b1);
    put(p);
    if (!ponly) begin
      put(v[15:8]);
      put(v[7:0]);
    end
    end_bytes();
  endtask
  // drop the strobe; the data lines show junk while idle
  task automatic end_bytes;
    wr_byte_vld = 1'b0;
    wr_byte = ~wr_byte;
  endtask
  task automatic rd(output logic [15:0] d);
    go(1'b0);
    rd_byte_req = 1'b1;
    @(posedge core_clk) #1 d[15:8] = rd_byte_ff;
    @(posedge core_clk) #1 rd_byte_req = 1'b0;
    d[7:0] = rd_byte_ff;
  endtask
endmodule // srpm_ctl
`default_nettype wire

// ==== sim/srpm_top_tb.sv ====
// self-checking bench for the pointer map
`timescale 1ns/1ps
`default_nettype none
module srpm_top_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic xfer_start, xfer_is_write, wr_byte_vld, rd_byte_req, rd_byte_vld_ff;
  logic result_vld = 1'b0;
  logic alert_level = 1'b1;
  logic [7:0] wr_byte, rd_byte_ff, pointer_ff;
  logic [15:0] result_data = 16'h0000;
  logic [15:0] temperature_result_ff, sensor_configuration_ff, d, e;
  logic [15:0] low_temperature_threshold_ff, high_temperature_threshold_ff;
  logic [1:0] conversion_rate_field_ff;
  int fails = 0;
  int n_tests = 0;
  always #12.5 core_clk = ~core_clk;
  srpm_top dut_u (
    .core_clk                      (core_clk),
    .rst                           (rst),
    .xfer_start                    (xfer_start),
    .xfer_is_write                 (xfer_is_write),
    .wr_byte_vld                   (wr_byte_vld),
    .wr_byte                       (wr_byte),
    .rd_byte_req                   (rd_byte_req),
    .result_vld                    (result_vld),
    .result_data                   (result_data),
    .alert_level                   (alert_level),
    .rd_byte_ff                    (rd_byte_ff),
    .rd_byte_vld_ff                (rd_byte_vld_ff),
    .pointer_ff                    (pointer_ff),
    .temperature_result_ff         (temperature_result_ff),
    .sensor_configuration_ff       (sensor_configuration_ff),
    .low_temperature_threshold_ff  (low_temperature_threshold_ff),
    .high_temperature_threshold_ff (high_temperature_threshold_ff),
    .conversion_rate_field_ff      (conversion_rate_field_ff)
  );
  srpm_ctl ctl_u (
    .core_clk      (core_clk),
    .rd_byte_ff    (rd_byte_ff),
    .xfer_start    (xfer_start),
    .xfer_is_write (xfer_is_write),
    .wr_byte_vld   (wr_byte_vld),
    .wr_byte       (wr_byte),
    .rd_byte_req   (rd_byte_req)
  );
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    #1 rst = 1'b0;
    chk("ptr", {8'h00, pointer_ff}, 16'h0000);
    chk("cfg", sensor_configuration_ff, 16'h40A0);
    chk("rate", {14'h0, conversion_rate_field_ff}, 16'h0002);
    for (int s = 1; s < 4; s++) begin
      // upper pointer bits set on purpose
      ctl_u.wr(8'hFC | s[7:0], 16'h5A00 + s[15:0], 1'b0);
      e = (s == 1) ? 16'h5A20 : 16'h5A00 + s[15:0];
      ctl_u.rd(d);
      chk("data", d, e);
      chk("vld", {15'h0000, rd_byte_vld_ff}, 16'h0001);
      chk("ptr", {8'h00, pointer_ff}, s[15:0]);
      chk("mir", s == 1 ? sensor_configuration_ff : s == 2 ? low_temperature_threshold_ff
        : high_temperature_threshold_ff, e);
    end
    @(posedge core_clk) #1 result_vld = 1'b1;
    result_data = 16'h8123;
    @(posedge core_clk) #1 result_vld = 1'b0;
    result_data = 16'h7EDC;
    chk("res", temperature_result_ff, 16'h8123);
    ctl_u.wr(8'h00, 16'hBEEF, 1'b0);
    ctl_u.rd(d);
    chk("ro", d, 16'h8123);
    ctl_u.wr(8'h06, 16'h0000, 1'b1);
    ctl_u.rd(d);
    chk("sel", d, 16'h5A02);
    // two full words then a lone high byte on the same register
    ctl_u.go(1'b1);
    ctl_u.put(8'h03);
    ctl_u.put(8'h11);
    ctl_u.put(8'h22);
    ctl_u.put(8'h33);
    ctl_u.put(8'h44);
    ctl_u.put(8'h55);
    ctl_u.end_bytes();
    ctl_u.rd(d);
    chk("wrap", d, 16'h3344);
    chk("hi", high_temperature_threshold_ff, 16'h3344);
    alert_level = 1'b0;
    ctl_u.wr(8'h01, 16'h0000, 1'b1);
    ctl_u.rd(d);
    chk("alert", d, 16'h5A00);
    test_done();
  end
endmodule // srpm_top_tb
`default_nettype wire
